// ### test/pes_host_model.sv
// Host serial controller model: one instruction byte per frame, MSB first
// Assumes the bench raises send with op stable and waits for busy to fall
`timescale 1ns/1ps
module pes_host_model (
    // Bench side
    input wire logic send,
    input wire logic [7:0] op,
    output logic busy,
    // Serial link
    output logic link_sclk,
    output logic link_cs_n,
    output logic link_si
);
    // ****************************************
    // Frame generator
    // ****************************************
    // Link clock stands low between frames, 80 ns period inside them
    initial begin
        busy = 1'b0;
        link_sclk = 1'b0;
        link_cs_n = 1'b1;
        link_si = 1'b0;
        forever begin
            @(posedge send);
            busy = 1'b1;
            #13 link_cs_n = 1'b0;
            for (int i = 7; i >= 0; i--) begin
                link_si = op[i];
                #40 link_sclk = 1'b1;
                #40 link_sclk = 1'b0;
            end
            #40 link_cs_n = 1'b1;
            link_si = ~link_si; // Released line shows no stale bit
            #120 busy = 1'b0;
        end
    end
endmodule : pes_host_model

// ### test/pes_seq_chk.sv
// Concurrent checks on the suspend/resume sequencer top-level ports
// Assumes binding onto pes_sequencer; every check lives in the sys_clk domain
`timescale 1ns/1ps
module pes_seq_chk #(
    parameter int PGM_SUSP_LAT_NS = 20000,
    parameter int ERS_SUSP_LAT_NS = 20000,
    parameter int LAT_CNT_W = 16
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Observed outputs
    input wire logic engine_run,
    input wire logic cmd_accept,
    input wire logic cmd_reject,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] status_word
);
    localparam int WIP_CYC = 40;
    logic suspend_flag;

    // Either suspend flag
    assign suspend_flag = status_word[15] | status_word[10];

    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    a_resume_clears: assert property (
        cmd_accept && cmd_code == 8'h7a |-> !suspend_flag ##[0:WIP_CYC] status_word[0])
        else $error("resume did not clear suspend or raise busy");
    a_resume_gated: assert property (
        cmd_accept && cmd_code == pes_pkg::OP_RESUME |-> $past(suspend_flag) && !$past(status_word[0]))
        else $error("resume accepted while not suspended or busy");
    a_reject_holds: assert property (
        cmd_reject |-> status_word == $past(status_word))
        else $error("rejected instruction changed the status");
    a_pgm_in_ers: assert property (
        cmd_accept && cmd_code inside {8'h02, 8'h12, 8'h32, 8'h34}
        |-> !$past(status_word[15]))
        else $error("page program accepted in program suspend");
    a_ers_in_pgm: assert property (
        cmd_accept && cmd_code inside {8'h20, 8'h21, 8'h52, 8'h5c, 8'hd8, 8'hdc}
        |-> !$past(status_word[10]))
        else $error("erase accepted in erase suspend");
    a_sus_waits: assert property (
        cmd_accept && cmd_code == pes_pkg::OP_SUSPEND |-> !suspend_flag [*8])
        else $error("suspend flag set before the latency");
    a_sus_entry: assert property (
        $rose(suspend_flag) |-> !status_word[1] && !status_word[0] && !engine_run)
        else $error("suspend entered with latch, busy or engine still set");
    a_one_kind: assert property (
        suspend_flag |-> !(status_word[15] && status_word[10]) && !status_word[0])
        else $error("both suspend flags or busy while suspended");
    a_no_self_run: assert property (
        $fell(suspend_flag) |-> cmd_accept && cmd_code inside {8'h7a, 8'h99})
        else $error("suspend left without resume or reset");

    // Main scenarios reached
    c_resume: cover property (cmd_accept && cmd_code == pes_pkg::OP_RESUME);
    c_pgm_sus: cover property ($rose(status_word[15]));
    c_ers_sus: cover property ($rose(status_word[10]));
endmodule : pes_seq_chk

// ### test/testbench.sv
// Self-checking bench for the suspend/resume sequencer
// Assumes pes_pkg, pes_sequencer, pes_host_model and pes_seq_chk are compiled first
`timescale 1ns/1ps
module testbench;
    localparam int LAT_NS = 4000;
    localparam logic [7:0] BOTH_OPS [0:28] = '{8'hc8, 8'hc5, 8'hb7, 8'he9, 8'h03, 8'h13,
        8'h0b, 8'h0d, 8'h0c, 8'h3b, 8'h6b, 8'hbb, 8'heb, 8'hed, 8'hee, 8'he7, 8'h77, 8'h90,
        8'h9f, 8'h4b, 8'hab, 8'h48, 8'h5a, 8'h2d, 8'ha7, 8'he2, 8'h3d, 8'haa, 8'h27};
    logic sys_clk, nrst, link_sclk, link_cs_n, link_si, reg_wr, reg_rd;
    logic engine_done, engine_run, engine_erase, cmd_accept, cmd_reject, send, host_busy;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, status_word;
    logic [7:0] cmd_code, host_op;
    int failures, checks, exp_rej, n_acc, n_rej;

    // ****************************************
    // Design, host model and clock
    // ****************************************
    pes_sequencer #(.PGM_SUSP_LAT_NS(LAT_NS), .ERS_SUSP_LAT_NS(LAT_NS), .LAT_CNT_W(16)) uut (
        .sys_clk(sys_clk), .nrst(nrst), .link_sclk(link_sclk), .link_cs_n(link_cs_n),
        .link_si(link_si), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .engine_done(engine_done),
        .engine_run(engine_run), .engine_erase(engine_erase), .cmd_accept(cmd_accept),
        .cmd_reject(cmd_reject), .cmd_code(cmd_code), .status_word(status_word));
    pes_host_model u_host (.send(send), .op(host_op), .busy(host_busy),
        .link_sclk(link_sclk), .link_cs_n(link_cs_n), .link_si(link_si));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Count admission pulses
    always @(posedge sys_clk) begin
        if (cmd_accept === 1'b1) n_acc <= n_acc + 1;
        if (cmd_reject === 1'b1) n_rej <= n_rej + 1;
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask : reg_write

    task automatic reg_read(input logic [3:0] a, input logic [15:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
        @(posedge sys_clk);
    endtask : reg_read

    // One frame, then the expected admission pulse and code
    task automatic send_op(input logic [7:0] op, input logic acc);
        int a0, r0;
        a0 = n_acc;
        r0 = n_rej;
        host_op <= op;
        send <= 1'b1;
        wait (host_busy === 1'b1);
        @(posedge sys_clk);
        send <= 1'b0;
        wait (host_busy === 1'b0);
        @(posedge sys_clk);
        check(16'(n_acc - a0), {15'h0, acc});
        check(16'(n_rej - r0), {15'h0, !acc});
        check({8'h0, cmd_code}, {8'h0, op});
        if (!acc) exp_rej++;
    endtask : send_op

    task automatic summarize();
        if (failures == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        nrst = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        engine_done = 1'b0;
        send = 1'b0;
        host_op = 8'h00;
        {failures, checks, exp_rej, n_acc, n_rej} = '0;
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        reg_read(pes_pkg::REG_STATUS, 16'h0000);
        reg_write(pes_pkg::REG_STATUS, 16'hffff);
        reg_read(pes_pkg::REG_STATUS, 16'h0000);
        reg_read(4'h9, 16'h0000);
        send_op(pes_pkg::OP_RESUME, 1'b0);
        // Program suspend: early commands, then the BOTH_OPS codes
        reg_write(pes_pkg::REG_CTRL, 16'h0001);
        reg_read(pes_pkg::REG_STATUS, 16'h0001);
        send_op(8'h03, 1'b0);
        send_op(pes_pkg::OP_SUSPEND, 1'b1);
        send_op(8'h05, 1'b1);
        send_op(8'h0b, 1'b0);
        send_op(pes_pkg::OP_RESUME, 1'b0);
        repeat (900) @(posedge sys_clk);
        reg_read(pes_pkg::REG_STATUS, 16'h8000);
        check({15'h0, engine_run}, 16'h0000);
        for (int i = 0; i < $size(BOTH_OPS); i++) begin
            send_op(BOTH_OPS[i], 1'b1);
        end
        send_op(8'h02, 1'b0);
        send_op(8'h34, 1'b0);
        send_op(8'hc7, 1'b0);
        send_op(pes_pkg::OP_SUSPEND, 1'b0);
        reg_read(pes_pkg::REG_STATUS, 16'h8000);
        reg_read(pes_pkg::REG_LAST_CMD, 16'h0075);
        reg_read(pes_pkg::REG_REJECTS, 16'(exp_rej));
        send_op(pes_pkg::OP_RESUME, 1'b1);
        reg_read(pes_pkg::REG_STATUS, 16'h0001);
        check({15'h0, engine_run}, 16'h0001);
        send_op(pes_pkg::OP_RESUME, 1'b0);
        engine_done <= 1'b1;
        @(posedge sys_clk);
        engine_done <= 1'b0;
        @(posedge sys_clk);
        reg_read(pes_pkg::REG_STATUS, 16'h0000);
        // Erase suspend cut short by a device reset
        reg_write(pes_pkg::REG_CTRL, 16'h0002);
        send_op(pes_pkg::OP_SUSPEND, 1'b1);
        send_op(pes_pkg::OP_RST_ENABLE, 1'b1);
        send_op(pes_pkg::OP_RST_DEVICE, 1'b1);
        reg_read(pes_pkg::REG_STATUS, 16'h0000);
        // Erase suspend after the latency, write latch set beforehand
        send_op(pes_pkg::OP_WR_ENABLE, 1'b1);
        reg_write(pes_pkg::REG_CTRL, 16'h0002);
        reg_read(pes_pkg::REG_STATUS, 16'h0003);
        send_op(pes_pkg::OP_SUSPEND, 1'b1);
        repeat (900) @(posedge sys_clk);
        reg_read(pes_pkg::REG_STATUS, 16'h0400);
        check(status_word, 16'h0400);
        reg_read(pes_pkg::REG_CTRL, 16'h0003);
        check({15'h0, engine_erase}, 16'h0001);
        send_op(pes_pkg::OP_WR_ENABLE, 1'b1);
        reg_read(pes_pkg::REG_STATUS, 16'h0402);
        send_op(pes_pkg::OP_WR_DISABLE, 1'b1);
        reg_read(pes_pkg::REG_STATUS, 16'h0400);
        send_op(8'h20, 1'b0);
        send_op(8'hdc, 1'b0);
        send_op(8'h35, 1'b1);
        send_op(8'h2d, 1'b1);
        send_op(8'h12, 1'b1);
        summarize();
    end

    // Watchdog well beyond the expected run of about 10.5k cycles
    initial begin
        #300000;
        failures++;
        summarize();
    end
endmodule : testbench

bind pes_sequencer pes_seq_chk #(.PGM_SUSP_LAT_NS(PGM_SUSP_LAT_NS),
    .ERS_SUSP_LAT_NS(ERS_SUSP_LAT_NS), .LAT_CNT_W(LAT_CNT_W)) u_chk (
    .sys_clk(sys_clk), .nrst(nrst), .engine_run(engine_run), .cmd_accept(cmd_accept),
    .cmd_reject(cmd_reject), .cmd_code(cmd_code), .status_word(status_word));

// ### verilog/pes_link_rx.sv
// Instruction byte receiver on the serial link clock
// Assumes the link clock runs only inside frames, chip select low-active
`timescale 1ns/1ps
module pes_link_rx (
    // Link side
    input wire logic link_sclk,
    input wire logic link_cs_n,
    input wire logic link_si,
    // Reset
    input wire logic nrst,
    // Toward the system domain
    output logic [7:0] op_hold,
    output logic op_toggle
);

    // ****************************************************************
    // Bit counter and shifter, cleared by the frame's own chip select
    // ****************************************************************
    logic [3:0] bit_cnt;
    logic [6:0] shift;
    logic [3:0] next_bit_cnt;
    logic [6:0] next_shift;
    logic [7:0] next_op_hold;
    logic next_op_toggle;

    // Next shift state, byte done on eighth bit
    always_comb begin
        next_bit_cnt = bit_cnt;
        next_shift = {shift[5:0], link_si};
        next_op_hold = op_hold;
        next_op_toggle = op_toggle;
        if (bit_cnt < 4'h8) begin
            next_bit_cnt = bit_cnt + 4'h1;
        end
        if (bit_cnt == 4'h7) begin
            next_op_hold = {shift, link_si};
            next_op_toggle = ~op_toggle;
        end
    end

    // Frame state, restarts with each chip select
    always_ff @(posedge link_sclk or posedge link_cs_n) begin
        if (link_cs_n) begin
            bit_cnt <= 4'h0;
            shift <= 7'h00;
        end else begin
            bit_cnt <= next_bit_cnt;
            shift <= next_shift;
        end
    end

    // Held opcode and event toggle survive frame end
    always_ff @(posedge link_sclk or negedge nrst) begin
        if (!nrst) begin
            op_hold <= 8'h00;
            op_toggle <= 1'b0;
        end else begin
            op_hold <= next_op_hold;
            op_toggle <= next_op_toggle;
        end
    end

endmodule : pes_link_rx

// ### verilog/pes_pkg.sv
// Constants, types and opcode classing for the suspend/resume sequencer
// Assumes a 200 MHz system clock and 8-bit serial instruction codes
//
// Contract
// - After latency, accept extended address register and 4-byte mode commands.
// - After latency, accept single-line array reads in either suspend.
// - After latency, accept all dual, quad and double-rate fast reads.
// - After latency, accept wrap setup, identification, power-down release, parameter reads.
// - Page program commands accepted only during erase suspend.
// - Sector and block erase commands accepted only during program suspend.
// - After latency, accept resume and protection register reads in both types.
// - Status register reads accepted any time after suspend, latency not needed.
// - Reset-enable and reset accepted right after suspend, latency not needed.
// - Resume acts only with suspend flag set and write-in-progress clear.
// - Accepted resume clears suspend at once, raises write-in-progress within 200 ns.
// - Resume with suspend clear or write-in-progress set is ignored entirely.
// - Program suspend reported in status bit 15, erase suspend in bit 10.
// - Suspend latency elapses before write latch clears and suspend flag sets.
package pes_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_PS = 5000;
    localparam int RESUME_WIP_MAX_NS = 200;
    localparam int RESUME_WIP_MAX_CYC = (RESUME_WIP_MAX_NS * 1000) / CLK_PERIOD_PS;

    // ****************************************************************
    // Instruction codes with own handling
    // ****************************************************************
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7a;
    localparam logic [7:0] OP_RST_ENABLE = 8'h66;
    localparam logic [7:0] OP_RST_DEVICE = 8'h99;
    localparam logic [7:0] OP_WR_ENABLE = 8'h06;
    localparam logic [7:0] OP_WR_DISABLE = 8'h04;

    // ****************************************************************
    // Register map and status layout
    // ****************************************************************
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_LAST_CMD = 4'h2;
    localparam logic [3:0] REG_REJECTS = 4'h3;
    localparam int CTRL_START_PGM = 0;
    localparam int CTRL_START_ERS = 1;
    localparam int ST_WIP = 0;
    localparam int ST_WEL = 1;
    localparam int ST_ERS_SUS = 10;
    localparam int ST_PGM_SUS = 15;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        CLS_NONE,
        CLS_ANYTIME,
        CLS_BOTH,
        CLS_ERS_ONLY,
        CLS_PGM_ONLY
    } pes_class_e;

    typedef struct packed {
        logic write_in_progress_flag;
        logic write_enable_latch;
        logic sus_pgm;
        logic sus_ers;
    } pes_flags_s;

    // Which suspend type admits an instruction
    function automatic pes_class_e pes_classify(input logic [7:0] op);
        unique case (op)
            8'h05, 8'h35, 8'h15, 8'h66, 8'h99: return CLS_ANYTIME;
            8'hc8, 8'hc5, 8'hb7, 8'he9, 8'hc2, 8'hf8, 8'h06, 8'h04,
            8'h03, 8'h13, 8'h0b, 8'h0d, 8'h0c,
            8'h3b, 8'h3c, 8'h6b, 8'h6c, 8'hbb, 8'hbd, 8'hbc,
            8'heb, 8'hed, 8'hec, 8'hee, 8'he7,
            8'h77, 8'h90, 8'h92, 8'h94, 8'h9f, 8'h4b, 8'hab, 8'h48, 8'h5a,
            8'h7a, 8'h2d, 8'ha7, 8'he2, 8'h3d, 8'haa, 8'h27: return CLS_BOTH;
            8'h02, 8'h12, 8'h32, 8'h34: return CLS_ERS_ONLY;
            8'h20, 8'h21, 8'h52, 8'h5c, 8'hd8, 8'hdc: return CLS_PGM_ONLY;
            default: return CLS_NONE;
        endcase
    endfunction : pes_classify

    // Status word from flags
    function automatic logic [15:0] pes_status_word(input pes_flags_s f);
        logic [15:0] w;
        w = 16'h0000;
        w[ST_WIP] = f.write_in_progress_flag;
        w[ST_WEL] = f.write_enable_latch;
        w[ST_ERS_SUS] = f.sus_ers;
        w[ST_PGM_SUS] = f.sus_pgm;
        return w;
    endfunction : pes_status_word

endpackage : pes_pkg

// ### verilog/pes_sequencer.sv
// Suspend and resume admission sequencer, top level
// Assumes the program/erase engine shares sys_clk and pulses done when finished
`timescale 1ns/1ps
module pes_sequencer #(
    parameter int PGM_SUSP_LAT_NS = 20000,
    parameter int ERS_SUSP_LAT_NS = 20000,
    parameter int LAT_CNT_W = 16
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Serial link
    input wire logic link_sclk,
    input wire logic link_cs_n,
    input wire logic link_si,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Program/erase engine
    input wire logic engine_done,
    output logic engine_run,
    output logic engine_erase,
    // Command admission
    output logic cmd_accept,
    output logic cmd_reject,
    output logic [7:0] cmd_code,
    // Status flags
    output logic [15:0] status_word
);

    // ****************************************************************
    // Latency counts
    // ****************************************************************
    localparam int PGM_LAT_CYC = (PGM_SUSP_LAT_NS * 1000 + pes_pkg::CLK_PERIOD_PS - 1)
                                 / pes_pkg::CLK_PERIOD_PS;
    localparam int ERS_LAT_CYC = (ERS_SUSP_LAT_NS * 1000 + pes_pkg::CLK_PERIOD_PS - 1)
                                 / pes_pkg::CLK_PERIOD_PS;

    // Refuse counts the counter cannot hold
    if (PGM_LAT_CYC < 1 || ERS_LAT_CYC < 1 || PGM_LAT_CYC >= (1 << LAT_CNT_W)
            || ERS_LAT_CYC >= (1 << LAT_CNT_W) || pes_pkg::RESUME_WIP_MAX_CYC < 1) begin : g_chk
        $error("suspend latency does not fit the counter");
    end

    localparam logic [LAT_CNT_W-1:0] PGM_LAT = LAT_CNT_W'(PGM_LAT_CYC);
    localparam logic [LAT_CNT_W-1:0] ERS_LAT = LAT_CNT_W'(ERS_LAT_CYC);
    localparam logic [LAT_CNT_W-1:0] LAT_ONE = LAT_CNT_W'(1);

    // ****************************************************************
    // Link receiver and event crossing
    // ****************************************************************
    // Crossing signals
    logic [7:0] link_op;
    logic link_toggle;
    logic tog_meta;
    logic tog_sync;
    logic tog_seen;
    logic op_event;
    logic [2:0] next_tog;

    pes_link_rx u_rx (
        .link_sclk(link_sclk),
        .link_cs_n(link_cs_n),
        .link_si(link_si),
        .nrst(nrst),
        .op_hold(link_op),
        .op_toggle(link_toggle)
    );

    // Next synchroniser stages, a bare shift with no logic between them
    always_comb begin
        next_tog = {tog_sync, tog_meta, link_toggle};
    end

    // Toggle synchroniser and edge memory
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tog_meta <= 1'b0;
            tog_sync <= 1'b0;
            tog_seen <= 1'b0;
        end else begin
            tog_meta <= next_tog[0];
            tog_sync <= next_tog[1];
            tog_seen <= next_tog[2];
        end
    end

    // Opcode word is stable for many link bits after the toggle
    assign op_event = tog_sync ^ tog_seen;

    // ****************************************************************
    // Sequencer state
    // ****************************************************************
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_BUSY = 4'b0010,
        ST_LATENCY = 4'b0100,
        ST_SUSPENDED = 4'b1000
    } pes_state_e;

    // State, flags and admission registers
    pes_state_e state;
    pes_state_e next_state;
    pes_pkg::pes_flags_s flags;
    pes_pkg::pes_flags_s next_flags;
    logic [LAT_CNT_W-1:0] lat_cnt;
    logic [LAT_CNT_W-1:0] next_lat_cnt;
    logic op_erase;
    logic next_op_erase;
    logic rst_armed;
    logic next_rst_armed;
    logic next_accept;
    logic next_reject;
    logic [7:0] next_code;
    logic [15:0] reject_cnt;
    logic [15:0] next_reject_cnt;
    pes_pkg::pes_class_e op_class;
    logic in_latency;

    // Classing reads the held word every cycle, its result used only while op_event marks it settled
    assign op_class = pes_pkg::pes_classify(link_op);
    assign in_latency = (state == ST_LATENCY);

    // Resume acts only from a settled suspend with the engine idle
    function automatic logic resume_allowed(input pes_pkg::pes_flags_s f);
        return !f.write_in_progress_flag && (f.sus_pgm || f.sus_ers);
    endfunction : resume_allowed

    // Next state, flags and admission decision
    always_comb begin
        next_state = state;
        next_flags = flags;
        next_lat_cnt = lat_cnt;
        next_op_erase = op_erase;
        next_rst_armed = rst_armed;
        next_accept = 1'b0;
        next_reject = 1'b0;
        next_code = cmd_code;
        next_reject_cnt = reject_cnt;
        unique case (state)
            ST_IDLE: begin
                // Software start is taken only from idle
                if (reg_wr && reg_addr == pes_pkg::REG_CTRL
                        && (reg_wdata[pes_pkg::CTRL_START_PGM]
                        || reg_wdata[pes_pkg::CTRL_START_ERS])) begin
                    next_state = ST_BUSY;
                    next_flags.write_in_progress_flag = 1'b1;
                    next_op_erase = reg_wdata[pes_pkg::CTRL_START_ERS];
                end
            end
            ST_BUSY: begin
                // A finish in the suspend cycle wins, nothing is left to hold
                if (engine_done) begin
                    next_state = ST_IDLE;
                    next_flags.write_in_progress_flag = 1'b0;
                    next_flags.write_enable_latch = 1'b0;
                end else if (op_event && link_op == pes_pkg::OP_SUSPEND) begin
                    next_state = ST_LATENCY;
                    next_lat_cnt = op_erase ? ERS_LAT : PGM_LAT;
                end
            end
            ST_LATENCY: begin
                // Flags move on the last latency cycle, never earlier
                if (lat_cnt == LAT_ONE) begin
                    next_state = ST_SUSPENDED;
                    next_flags.write_in_progress_flag = 1'b0;
                    next_flags.write_enable_latch = 1'b0;
                    next_flags.sus_pgm = ~op_erase;
                    next_flags.sus_ers = op_erase;
                end
                next_lat_cnt = lat_cnt - LAT_ONE;
            end
            ST_SUSPENDED: begin
                // Held here until a resume or a device reset below
            end
        endcase

        // Admission of instruction codes
        // During the latency only the anytime class gets through
        if (op_event) begin
            next_code = link_op;
            if (state == ST_SUSPENDED || in_latency) begin
                unique case (op_class)
                    pes_pkg::CLS_ANYTIME: next_accept = 1'b1;
                    pes_pkg::CLS_BOTH: begin
                        next_accept = !in_latency;
                    end
                    pes_pkg::CLS_ERS_ONLY: next_accept = !in_latency && op_erase;
                    pes_pkg::CLS_PGM_ONLY: next_accept = !in_latency && !op_erase;
                    pes_pkg::CLS_NONE: next_accept = 1'b0;
                endcase
                next_reject = !next_accept;
            end else if (state == ST_BUSY) begin
                next_accept = (op_class == pes_pkg::CLS_ANYTIME)
                              || (link_op == pes_pkg::OP_SUSPEND);
                next_reject = !next_accept;
            end else begin
                next_accept = (link_op != pes_pkg::OP_RESUME);
                next_reject = !next_accept;
            end
        end

        // Effects of accepted codes
        if (next_accept) begin
            // Suspend flags drop and busy rises on the same edge
            if (link_op == pes_pkg::OP_RESUME && resume_allowed(flags)) begin
                next_state = ST_BUSY;
                next_flags.sus_pgm = 1'b0;
                next_flags.sus_ers = 1'b0;
                next_flags.write_in_progress_flag = 1'b1;
            end
            if (link_op == pes_pkg::OP_WR_ENABLE) begin
                next_flags.write_enable_latch = 1'b1;
            end
            if (link_op == pes_pkg::OP_WR_DISABLE) begin
                next_flags.write_enable_latch = 1'b0;
            end
            next_rst_armed = (link_op == pes_pkg::OP_RST_ENABLE);
            // Reset acts only when the enable was the last accepted code
            if (link_op == pes_pkg::OP_RST_DEVICE && rst_armed) begin
                next_state = ST_IDLE;
                next_flags = '0;
                next_lat_cnt = '0;
                next_op_erase = 1'b0; // Nothing is left suspended
            end
        end
        // Every ignored code is counted for software
        if (next_reject) begin
            next_reject_cnt = reject_cnt + 16'h0001;
        end
    end

    // Sequencer registers
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
            flags <= '0;
            lat_cnt <= '0;
            op_erase <= 1'b0;
            rst_armed <= 1'b0;
            cmd_accept <= 1'b0;
            cmd_reject <= 1'b0;
            cmd_code <= 8'h00;
            reject_cnt <= 16'h0000;
        end else begin
            state <= next_state;
            flags <= next_flags;
            lat_cnt <= next_lat_cnt;
            op_erase <= next_op_erase;
            rst_armed <= next_rst_armed;
            cmd_accept <= next_accept;
            cmd_reject <= next_reject;
            cmd_code <= next_code;
            reject_cnt <= next_reject_cnt;
        end
    end

    // ****************************************************************
    // Outputs and register reads
    // ****************************************************************
    logic [15:0] next_rdata;
    logic next_engine_run;
    logic next_engine_erase;
    logic [15:0] next_status_word;

    // Read mux, unmapped reads return zero
    always_comb begin
        next_rdata = 16'h0000;
        if (reg_rd) begin
            unique case (reg_addr)
                pes_pkg::REG_STATUS: next_rdata = pes_pkg::pes_status_word(flags);
                pes_pkg::REG_LAST_CMD: next_rdata = {8'h00, cmd_code};
                pes_pkg::REG_REJECTS: next_rdata = reject_cnt;
                pes_pkg::REG_CTRL: next_rdata = {14'h0000, op_erase, state != ST_IDLE};
                default: next_rdata = 16'h0000;
            endcase
        end
        // Engine runs while busy and while the latency runs out
        next_engine_run = (next_state == ST_BUSY) || (next_state == ST_LATENCY);
        next_engine_erase = next_op_erase;
        next_status_word = pes_pkg::pes_status_word(next_flags);
    end

    // Registered outputs
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 16'h0000;
            engine_run <= 1'b0;
            engine_erase <= 1'b0;
            status_word <= 16'h0000;
        end else begin
            reg_rdata <= next_rdata;
            engine_run <= next_engine_run;
            engine_erase <= next_engine_erase;
            status_word <= next_status_word;
        end
    end

endmodule : pes_sequencer
